// file: design/caf_accept_filter.sv
// acceptance filter bank: configuration registers and frame acceptance
// Function
// - control bit 0 set unlocks filter configuration, clear locks it.
// - mode, scale and queue registers take writes only while unlocked.
// - mode bits 27:0: zero is identifier-plus-mask, one is identifier list.
// - scale bit per filter: zero gives 16-bit scale, one gives 32-bit scale.
// - queue bit per filter: zero routes to receive FIFO 0, one to FIFO 1.
// - active bit enables its filter; disabled filters never accept frames.
// - two pattern words per filter at base plus 8 times filter plus 4 times word.
// - mask mode: a one compares the identifier bit, a zero ignores it.
// - list mode: each pattern bit is the exact identifier bit required.
// - every register is accessed only as a whole aligned 32-bit word.
// - banks below the split serve controller 0, the rest controller 1.
`timescale 1ns/1ns
module caf_accept_filter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [caf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [caf_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [caf_pkg::DATA_W-1:0] regRdData,
  input wire logic frameValid,
  input wire logic [caf_pkg::DATA_W-1:0] frameId,
  input wire logic frameController,
  output logic resultValid,
  output logic resultAccept,
  output logic resultQueue,
  output logic [caf_pkg::IDX_W-1:0] resultIndex,
  output logic filterUnlocked
);

  localparam int unsigned NF = caf_pkg::NUM_FILTERS;

  // configuration state
  logic filter_unlock;
  logic [caf_pkg::SPLIT_W-1:0] second_controller_first_bank;
  logic [NF-1:0] filter_list_mode;
  logic [NF-1:0] filter_wide_scale;
  logic [NF-1:0] filter_queue_choice;
  logic [NF-1:0] filter_active_bit;
  logic [caf_pkg::DATA_W-1:0] patternMem [caf_pkg::PATTERN_WORDS];

  // last match record
  logic statHit;
  logic statQueue;
  logic statCtrl;
  logic [caf_pkg::IDX_W-1:0] statIndex;

  // decoded accesses
  logic wordAccess;
  logic wrControl;
  logic wrStyle;
  logic wrWidth;
  logic wrQueue;
  logic wrActive;
  logic wrPattern;
  logic [caf_pkg::SLOT_W-1:0] accSlot;
  logic [caf_pkg::DATA_W-1:0] next_regRdData;

  // matching
  logic [NF-1:0] rawHit;
  logic [NF-1:0] ownedBank;
  logic [NF-1:0] eligible;
  logic anyHit;
  logic [caf_pkg::IDX_W-1:0] firstHit;

  // address lies on a pattern word
  function automatic logic inPatternRange(input logic [caf_pkg::ADDR_W-1:0] a);
    inPatternRange = (a >= caf_pkg::OFS_PATTERN_BASE) && (a <= caf_pkg::OFS_PATTERN_LAST);
  endfunction

  // pattern word slot: filter number times two plus word index
  function automatic logic [caf_pkg::SLOT_W-1:0] patternSlot(
    input logic [caf_pkg::ADDR_W-1:0] a
  );
    logic [caf_pkg::ADDR_W-1:0] rel;
    rel = (a - caf_pkg::OFS_PATTERN_BASE) >> caf_pkg::WORD_SHIFT;
    patternSlot = rel[caf_pkg::SLOT_W-1:0];
  endfunction

  // bank register image with the unused top bits reading as zero
  function automatic logic [caf_pkg::DATA_W-1:0] bankImage(input logic [NF-1:0] v);
    bankImage = {{(caf_pkg::DATA_W - NF){1'b0}}, v};
  endfunction

  // misaligned addresses are ignored entirely
  assign wordAccess = (regAddr & caf_pkg::WORD_ALIGN_MASK) == '0;
  assign accSlot = patternSlot(regAddr);

  assign wrControl = regWr && wordAccess && (regAddr == caf_pkg::OFS_CONTROL);
  assign wrStyle = regWr && wordAccess && (regAddr == caf_pkg::OFS_MATCH_STYLE)
                   && filter_unlock;
  assign wrWidth = regWr && wordAccess && (regAddr == caf_pkg::OFS_WIDTH_SELECT)
                   && filter_unlock;
  assign wrQueue = regWr && wordAccess && (regAddr == caf_pkg::OFS_QUEUE_SELECT)
                   && filter_unlock;
  assign wrActive = regWr && wordAccess && (regAddr == caf_pkg::OFS_ACTIVE);
  assign wrPattern = regWr && wordAccess && inPatternRange(regAddr);

  // control register: unlock bit and controller split
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_unlock <= caf_pkg::CTRL_UNLOCK_RST;
      second_controller_first_bank <= caf_pkg::CTRL_SPLIT_RST;
    end else if (clkEn && wrControl) begin
      filter_unlock <= regWrData[caf_pkg::CTRL_UNLOCK_BIT];
      second_controller_first_bank <=
        regWrData[caf_pkg::CTRL_SPLIT_LSB +: caf_pkg::SPLIT_W];
    end
  end

  // mode register, writable only while unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_list_mode <= caf_pkg::BANK_RST;
    end else if (clkEn && wrStyle) begin
      filter_list_mode <= regWrData[NF-1:0];
    end
  end

  // scale register, writable only while unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_wide_scale <= caf_pkg::BANK_RST;
    end else if (clkEn && wrWidth) begin
      filter_wide_scale <= regWrData[NF-1:0];
    end
  end

  // queue selection register, writable only while unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_queue_choice <= caf_pkg::BANK_RST;
    end else if (clkEn && wrQueue) begin
      filter_queue_choice <= regWrData[NF-1:0];
    end
  end

  // active register, writable at any time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_active_bit <= caf_pkg::BANK_RST;
    end else if (clkEn && wrActive) begin
      filter_active_bit <= regWrData[NF-1:0];
    end
  end

  // pattern words are plain storage without reset
  always_ff @(posedge core_clk) begin
    if (clkEn && wrPattern) begin
      patternMem[accSlot] <= regWrData;
    end
  end

  // read multiplexer; unmapped or misaligned reads return zero
  always_comb begin
    next_regRdData = '0;
    if (regRd && wordAccess) begin
      if (regAddr == caf_pkg::OFS_CONTROL) begin
        next_regRdData = caf_pkg::CTRL_RESERVED_VAL;
        next_regRdData[caf_pkg::CTRL_UNLOCK_BIT] = filter_unlock;
        next_regRdData[caf_pkg::CTRL_SPLIT_LSB +: caf_pkg::SPLIT_W] =
          second_controller_first_bank;
      end else if (regAddr == caf_pkg::OFS_MATCH_STYLE) begin
        next_regRdData = bankImage(filter_list_mode);
      end else if (regAddr == caf_pkg::OFS_WIDTH_SELECT) begin
        next_regRdData = bankImage(filter_wide_scale);
      end else if (regAddr == caf_pkg::OFS_QUEUE_SELECT) begin
        next_regRdData = bankImage(filter_queue_choice);
      end else if (regAddr == caf_pkg::OFS_ACTIVE) begin
        next_regRdData = bankImage(filter_active_bit);
      end else if (regAddr == caf_pkg::OFS_MATCH_STATUS) begin
        next_regRdData[caf_pkg::STAT_INDEX_LSB +: caf_pkg::IDX_W] = statIndex;
        next_regRdData[caf_pkg::STAT_QUEUE_BIT] = statQueue;
        next_regRdData[caf_pkg::STAT_HIT_BIT] = statHit;
        next_regRdData[caf_pkg::STAT_CTRL_BIT] = statCtrl;
      end else if (inPatternRange(regAddr)) begin
        next_regRdData = patternMem[accSlot];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (clkEn) begin
      regRdData <= next_regRdData;
    end
  end

  // one comparator per filter plus bank ownership
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gFilter
      caf_filter_match uMatch (
        .listMode (filter_list_mode[g]),
        .wideScale (filter_wide_scale[g]),
        .word0 (patternMem[2 * g]),
        .word1 (patternMem[2 * g + 1]),
        .frameId (frameId),
        .hit (rawHit[g])
      );
      // split at or above the bank count leaves controller 1 with nothing
      assign ownedBank[g] = frameController
                            ? (caf_pkg::SPLIT_W'(g) >= second_controller_first_bank)
                            : (caf_pkg::SPLIT_W'(g) < second_controller_first_bank);
      assign eligible[g] = rawHit[g] && filter_active_bit[g] && ownedBank[g];
    end
  endgenerate

  // lowest numbered eligible filter wins
  always_comb begin
    anyHit = 1'b0;
    firstHit = '0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        anyHit = 1'b1;
        firstHit = caf_pkg::IDX_W'(i);
      end
    end
  end

  // acceptance result, one cycle after the frame strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resultValid <= 1'b0;
      resultAccept <= 1'b0;
      resultQueue <= 1'b0;
      resultIndex <= '0;
    end else if (clkEn) begin
      resultValid <= frameValid;
      resultAccept <= frameValid && anyHit;
      if (frameValid) begin
        resultQueue <= anyHit && filter_queue_choice[firstHit];
        resultIndex <= firstHit;
      end
    end
  end

  // software-visible record of the last frame's outcome
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      statHit <= 1'b0;
      statQueue <= 1'b0;
      statCtrl <= 1'b0;
      statIndex <= '0;
    end else if (clkEn && frameValid) begin
      statHit <= anyHit;
      statQueue <= anyHit && filter_queue_choice[firstHit];
      statCtrl <= frameController;
      statIndex <= firstHit;
    end
  end

  // unlock state mirrored for the receive path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filterUnlocked <= caf_pkg::CTRL_UNLOCK_RST;
    end else if (clkEn) begin
      filterUnlocked <= (wrControl ? regWrData[caf_pkg::CTRL_UNLOCK_BIT] : filter_unlock);
    end
  end

endmodule // caf_accept_filter

// file: design/caf_pkg.sv
// shared constants for the acceptance filter configuration block
package caf_pkg;

  localparam int unsigned NUM_FILTERS = 28;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned SPLIT_W = 6;
  localparam int unsigned SLOT_W = 6;
  localparam int unsigned PATTERN_WORDS = 2 * NUM_FILTERS;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_MATCH_STYLE = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_WIDTH_SELECT = 12'h20c;
  localparam logic [ADDR_W-1:0] OFS_QUEUE_SELECT = 12'h214;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 12'h21c;
  localparam logic [ADDR_W-1:0] OFS_MATCH_STATUS = 12'h230;
  localparam logic [ADDR_W-1:0] OFS_PATTERN_BASE = 12'h240;
  localparam logic [ADDR_W-1:0] OFS_PATTERN_LAST = 12'h31c;
  localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK = 12'h003;
  localparam int unsigned WORD_SHIFT = 2;

  // control register layout
  localparam int unsigned CTRL_UNLOCK_BIT = 0;
  localparam int unsigned CTRL_SPLIT_LSB = 8;
  localparam logic CTRL_UNLOCK_RST = 1'h1;
  localparam logic [SPLIT_W-1:0] CTRL_SPLIT_RST = 6'h0e;
  localparam logic [DATA_W-1:0] CTRL_RESERVED_VAL = 32'h2a1c0000;

  // per-filter bank registers
  localparam logic [NUM_FILTERS-1:0] BANK_RST = 28'h0000000;

  // match status register layout
  localparam int unsigned STAT_INDEX_LSB = 0;
  localparam int unsigned STAT_QUEUE_BIT = 8;
  localparam int unsigned STAT_HIT_BIT = 16;
  localparam int unsigned STAT_CTRL_BIT = 24;

  // identifier word layout as seen on the receive path
  localparam int unsigned FRAME_STD_LSB = 21;
  localparam int unsigned FRAME_STD_W = 11;
  localparam int unsigned FRAME_EXT_HI_LSB = 18;
  localparam int unsigned FRAME_EXT_HI_W = 3;
  localparam int unsigned FRAME_FF_BIT = 2;
  localparam int unsigned FRAME_FT_BIT = 1;

endpackage

// file: design/caf_filter_match.sv
// identifier comparison for one acceptance filter
`timescale 1ns/1ns
module caf_filter_match (
  input wire logic listMode,
  input wire logic wideScale,
  input wire logic [caf_pkg::DATA_W-1:0] word0,
  input wire logic [caf_pkg::DATA_W-1:0] word1,
  input wire logic [caf_pkg::DATA_W-1:0] frameId,
  output logic hit
);

  logic [caf_pkg::HALF_W-1:0] shortId;

  // compared bits are those whose care bit is one
  function automatic logic careMatch(
    input logic [caf_pkg::DATA_W-1:0] id,
    input logic [caf_pkg::DATA_W-1:0] pat,
    input logic [caf_pkg::DATA_W-1:0] care
  );
    careMatch = ((id ^ pat) & care) == '0;
  endfunction

  // short image: standard id, remote flag, extended flag, top extended bits
  assign shortId = {frameId[caf_pkg::FRAME_STD_LSB +: caf_pkg::FRAME_STD_W],
                    frameId[caf_pkg::FRAME_FT_BIT],
                    frameId[caf_pkg::FRAME_FF_BIT],
                    frameId[caf_pkg::FRAME_EXT_HI_LSB +: caf_pkg::FRAME_EXT_HI_W]};

  always_comb begin
    unique case ({listMode, wideScale})
      // wide mask: word0 identifier, word1 mask
      2'h1: hit = careMatch(frameId, word0, word1);
      // wide list: two exact identifiers
      2'h3: hit = (frameId == word0) || (frameId == word1);
      // short mask: low half identifier, high half mask, two pairs
      2'h0: hit = careMatch({16'h0000, shortId}, {16'h0000, word0[caf_pkg::HALF_W-1:0]},
                            {16'h0000, word0[caf_pkg::DATA_W-1:caf_pkg::HALF_W]})
               || careMatch({16'h0000, shortId}, {16'h0000, word1[caf_pkg::HALF_W-1:0]},
                            {16'h0000, word1[caf_pkg::DATA_W-1:caf_pkg::HALF_W]});
      // short list: four exact identifiers
      default: hit = (shortId == word0[caf_pkg::HALF_W-1:0])
                  || (shortId == word0[caf_pkg::DATA_W-1:caf_pkg::HALF_W])
                  || (shortId == word1[caf_pkg::HALF_W-1:0])
                  || (shortId == word1[caf_pkg::DATA_W-1:caf_pkg::HALF_W]);
    endcase
  end

endmodule // caf_filter_match

// file: verification/caf_accept_filter_asserts.sv
// port checker for the acceptance filter bank
`timescale 1ns/1ns
module caf_accept_filter_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [caf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [caf_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [caf_pkg::DATA_W-1:0] regRdData,
  input wire logic frameValid,
  input wire logic [caf_pkg::DATA_W-1:0] frameId,
  input wire logic frameController,
  input wire logic resultValid,
  input wire logic resultAccept,
  input wire logic resultQueue,
  input wire logic [caf_pkg::IDX_W-1:0] resultIndex,
  input wire logic filterUnlocked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ctlWr;
    clkEn && regWr && regAddr == caf_pkg::OFS_CONTROL;
  endsequence
  sequence actWrRd;
    clkEn && regWr && regAddr == caf_pkg::OFS_ACTIVE ##1
      clkEn && regRd && regAddr == caf_pkg::OFS_ACTIVE;
  endsequence
  AST_UNLOCK_SET: assert property ((ctlWr ##0 regWrData[0]) |=> filterUnlocked)
    else $error("unlock bit not set by control write");
  AST_UNLOCK_CLR: assert property ((ctlWr ##0 !regWrData[0]) |=> !filterUnlocked)
    else $error("unlock bit not cleared by control write");
  AST_UNLOCK_HOLD: assert property (!(clkEn && regWr && regAddr == caf_pkg::OFS_CONTROL)
    |=> $stable(filterUnlocked)) else $error("unlock bit changed without control write");
  AST_ACTIVE_READBACK: assert property (actWrRd |=>
    regRdData == ($past(regWrData, 2) & 32'h0fffffff)) else $error("active readback wrong");
  AST_RESULT_PULSE: assert property (clkEn && frameValid |=> resultValid)
    else $error("no result one cycle after frame");
  AST_RESULT_QUIET: assert property (clkEn && !frameValid |=> !resultValid && !resultAccept)
    else $error("result without frame");
  AST_ACCEPT_VALID: assert property (resultAccept |-> resultValid)
    else $error("accept outside result pulse");
  AST_REJECT_QUEUE: assert property (resultValid && !resultAccept |-> !resultQueue)
    else $error("queue set on rejected frame");
  AST_RESULT_HOLD: assert property (clkEn && !frameValid
    |=> $stable(resultQueue) && $stable(resultIndex)) else $error("result changed without frame");
  AST_RDATA_IDLE: assert property (clkEn && !regRd |=> regRdData == '0)
    else $error("read data outside read answer");
  AST_MISALIGNED_READ: assert property (clkEn && regRd && regAddr[1:0] != 2'h0
    |=> regRdData == '0) else $error("misaligned read returned data");
endmodule // caf_accept_filter_asserts

bind caf_accept_filter caf_accept_filter_asserts i_caf_accept_filter_asserts (.core_clk, .rst_n,
  .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .frameValid, .frameId,
  .frameController, .resultValid, .resultAccept, .resultQueue, .resultIndex, .filterUnlocked);

// file: verification/caf_accept_filter_tb_top.sv
// self-checking bench for the acceptance filter bank
`timescale 1ns/1ns
module caf_accept_filter_tb_top;
  typedef struct packed {logic [31:0] id; logic ctl; logic acc; logic q; logic [4:0] idx;} caf_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic frameValid = 1'b0;
  logic [31:0] frameId = 32'h0;
  logic frameController = 1'b0;
  logic resultValid;
  logic resultAccept;
  logic resultQueue;
  logic [4:0] resultIndex;
  logic filterUnlocked;
  int badCount = 0;
  int nChecks = 0;
  int cycles = 0;
  logic [43:0] cfg [16] = '{{12'h240, 32'h12340000}, {12'h244, 32'hffff0000},
    {12'h248, 32'haaaa0004}, {12'h24c, 32'h55550006}, {12'h250, 32'hfff01230},
    {12'h254, 32'hffff7777}, {12'h258, 32'h0a0a0b0b}, {12'h25c, 32'h0c0c0d0d},
    {12'h260, 32'hcccc0000}, {12'h264, 32'hffff0000}, {12'h2e0, 32'h12340000},
    {12'h2e4, 32'hffff0000}, {12'h204, 32'h0000000a}, {12'h20c, 32'h00100003},
    {12'h214, 32'h00000009}, {12'h21c, 32'h0010000f}};
  caf_row_t rows [9] = '{{32'h1234abcd, 3'b011, 5'h00}, {32'h1234abcd, 3'b110, 5'h14},
    {32'haaaa0004, 3'b010, 5'h01}, {32'h55550006, 3'b010, 5'h01}, {32'haaaa0005, 3'b000, 5'h00},
    {32'h12300003, 3'b010, 5'h02}, {32'h0d140004, 3'b011, 5'h03}, {32'h0c100004, 3'b011, 5'h03},
    {32'hcccc1111, 3'b000, 5'h00}};

  caf_accept_filter i_caf_accept_filter (.core_clk, .rst_n, .clkEn, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .frameValid, .frameId, .frameController, .resultValid,
    .resultAccept, .resultQueue, .resultIndex, .filterUnlocked);

  always #20 core_clk = ~core_clk;

  task automatic finalReport();
    if (badCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      finalReport();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      badCount++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  task automatic frame(input caf_row_t r);
    @(posedge core_clk);
    frameValid <= 1'b1;
    frameId <= r.id;
    frameController <= r.ctl;
    @(posedge core_clk);
    frameValid <= 1'b0;
    #1 chk({31'h0, resultValid}, 32'h1);
    chk({31'h0, resultAccept}, {31'h0, r.acc});
    chk({31'h0, resultQueue}, {31'h0, r.q});
    if (r.acc) chk({27'h0, resultIndex}, {27'h0, r.idx});
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk({31'h0, filterUnlocked}, 32'h1);
    rc(12'h200, 32'h2a1c0e01);
    for (int i = 12; i < 16; i++) rc(cfg[i][43:32], 32'h0);
    for (int i = 0; i < 16; i++) wr(cfg[i][43:32], cfg[i][31:0]);
    rc(12'h2e4, 32'hffff0000);
    for (int i = 0; i < 9; i++) frame(rows[i]);
    // locked: mode, scale and queue writes must be dropped; split kept at 14
    wr(12'h200, 32'h00000e00);
    chk({31'h0, filterUnlocked}, 32'h0);
    wr(12'h204, 32'hffffffff);
    wr(12'h20c, 32'h0);
    wr(12'h214, 32'h0);
    rc(12'h204, 32'h0000000a);
    rc(12'h20c, 32'h00100003);
    rc(12'h214, 32'h00000009);
    frame(rows[0]);
    // write then read back to back, reserved bits dropped
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= 12'h21c;
    regWrData <= 32'hf010000e;
    @(posedge core_clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, 32'h0010000e);
    frame({32'h1234abcd, 3'b000, 5'h00});
    wr(12'h21e, 32'hffffffff);
    rc(12'h21c, 32'h0010000e);
    rc(12'h21d, 32'h0);
    rc(12'h3f0, 32'h0);
    // split at zero hands every bank to the second controller
    wr(12'h200, 32'h00000001);
    rc(12'h200, 32'h2a1c0001);
    wr(12'h21c, 32'h0010000f);
    frame({32'h1234abcd, 3'b000, 5'h00});
    frame({32'h1234abcd, 3'b111, 5'h00});
    wr(12'h204, 32'hf000000b);
    rc(12'h204, 32'h0000000b);
    frame({32'h1234abcd, 3'b110, 5'h14});
    rc(12'h230, 32'h01010014);
    // clock enable low: a write must leave the active register untouched
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(12'h21c, 32'h0);
    @(posedge core_clk);
    clkEn <= 1'b1;
    rc(12'h21c, 32'h0010000f);
    finalReport();
  end
endmodule // caf_accept_filter_tb_top
